// >>> core/tdc_terminal_ctl.sv
// Purpose: Terminal control register, volatile wipers and ladder tap decode
// Assumes: Commands arrive already parsed from the serial engine, synchronous
// Notes:   cmd_done marks the end of a whole serial command (stop)
module tdc_terminal_ctl
   import tdc_pkg::*;
#(
   parameter int        NUM_NETS    = 2,
   parameter int        RES_BITS    = 8,
   parameter tdc_word_t WIPER_RESET = WIPER_MID_8,
   parameter int        TAPS        = (1 << RES_BITS) + 1
) (
   input  wire logic                     mclk,
   input  wire logic                     rstn,
   input  wire logic                     cmd_valid,
   input  wire tdc_op_t                  cmd_op,
   input  wire logic [3:0]               cmd_addr,
   input  wire tdc_word_t                cmd_wdata,
   input  wire logic                     cmd_done,
   input  wire logic                     net0_lock,
   input  wire logic                     net1_lock,
   output logic [8:0]                    rd_data,
   output logic                          rd_valid,
   output logic                          general_call_accept_enable,
   output logic [NUM_NETS*TAPS-1:0]      tap_sel,
   output logic [NUM_NETS-1:0]           term_a_sw,
   output logic [NUM_NETS-1:0]           term_b_sw,
   output logic [NUM_NETS-1:0]           wiper_sw,
   output logic [NUM_NETS-1:0]           wiper_to_b_sw
);
   localparam tdc_word_t FULL = tdc_full_scale(RES_BITS);

   tdc_word_t tctl_q;
   tdc_word_t tctl_live_q;
   tdc_word_t wiper_q [NUM_NETS];
   logic      seen_q;

   // Step a wiper; both steps are refused in the reserved band above full
   function automatic tdc_word_t next_wiper(input tdc_word_t cur,
                                            input tdc_op_t   op,
                                            input tdc_word_t wdata);
      unique case (op)
         TDC_OP_WRITE: return wdata;
         TDC_OP_INC:   return (cur < FULL) ? tdc_word_t'(cur + 9'h001) : cur;
         TDC_OP_DEC:   return (cur != WIPER_ZERO && cur <= FULL) ?
                              tdc_word_t'(cur - 9'h001) : cur;
         TDC_OP_READ:  return cur;
      endcase
   endfunction : next_wiper

   // Decode of the terminal control write and its lock mask
   wire logic      [1:0] lock    = {net1_lock, net0_lock};
   wire logic            is_wr   = cmd_valid & (cmd_op == TDC_OP_WRITE);
   wire logic            tctl_wr = is_wr & (cmd_addr == ADDR_TERM_CTL);
   wire tdc_word_t       wr_mask = {1'b1, {NET_FIELD_W{~lock[1]}},
                                    {NET_FIELD_W{~lock[0]}}};
   wire tdc_word_t       tctl_d  = tctl_wr ?
                                   ((tctl_q & ~wr_mask) | (cmd_wdata & wr_mask)) : tctl_q;
   // Live copy only moves at command end, so switches never glitch mid-transfer
   wire tdc_word_t       live_d  = cmd_done ? tctl_d : tctl_live_q;

   // Readback mux; unmapped addresses answer zero
   wire logic            rd_req  = cmd_valid & (cmd_op == TDC_OP_READ);
   wire tdc_word_t       rd_sel  =
      (cmd_addr == ADDR_TERM_CTL) ? tctl_q :
      (cmd_addr == ADDR_WIPER0) ? wiper_q[0] :
      (cmd_addr == ADDR_WIPER1 && NUM_NETS > 1) ? wiper_q[NUM_NETS-1] : WIPER_ZERO;

   assign general_call_accept_enable = tctl_live_q[GC_ACCEPT_POS];

   // Terminal control storage, staged and live
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tctl_q      <= TERM_CTL_RESET;
         tctl_live_q <= TERM_CTL_RESET;
         seen_q      <= 1'b0;
      end else begin
         tctl_q      <= tctl_d;
         tctl_live_q <= live_d;
         seen_q      <= 1'b1;
      end
   end

   // Read data register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rd_data  <= 9'h000;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_req;
         if (rd_req) begin
            rd_data <= rd_sel;
         end
      end
   end

   // One wiper register and one decoder per network
   for (genvar n = 0; n < NUM_NETS; n++) begin : g_net                 
      localparam int        LSB  = n * NET_FIELD_W;
      localparam logic[3:0] WADR = (n == 0) ? ADDR_WIPER0 : ADDR_WIPER1;

      wire logic hit = cmd_valid & (cmd_addr == WADR) & ~lock[n];

      tdc_tap_if #(.TAPS(TAPS)) tap_i ();

      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            wiper_q[n] <= WIPER_RESET;
         end else if (hit) begin
            wiper_q[n] <= next_wiper(wiper_q[n], cmd_op, cmd_wdata);
         end
      end

      // Each network reads only its own field of the live copy
      assign tap_i.wiper = wiper_q[n];
      assign tap_i.run   = tctl_live_q[LSB+FLD_RUN];
      assign tap_i.con_a = tctl_live_q[LSB+FLD_A];
      assign tap_i.con_w = tctl_live_q[LSB+FLD_W];
      assign tap_i.con_b = tctl_live_q[LSB+FLD_B];

      tdc_tap_decode #(.RES_BITS(RES_BITS)) u_dec (
         .mclk (mclk),
         .rstn (rstn),
         .tap  (tap_i.dec)
      );

      assign tap_sel[n*TAPS +: TAPS] = tap_i.tap_sel;
      assign term_a_sw[n]            = tap_i.sw_a;
      assign term_b_sw[n]            = tap_i.sw_b;
      assign wiper_sw[n]             = tap_i.sw_w;
      assign wiper_to_b_sw[n]        = tap_i.sw_wb_short;
   end

   // Checks on network 0 and the shared register
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   // Command strobe of any opcode to wiper 0 that the lock lets through
   wire logic hit_full = cmd_valid & (cmd_addr == ADDR_WIPER0) & ~net0_lock;

   a_reset_all_ones: assert property (!seen_q |-> tctl_q == TERM_CTL_RESET)
      else $error("terminal control not all ones after reset");
   a_lock1_holds: assert property (tctl_wr && net1_lock |=>
      tctl_q[7:4] == $past(tctl_q[7:4]))
      else $error("network 1 bits changed while locked");
   a_lock0_holds: assert property (tctl_wr && net0_lock |=>
      tctl_q[3:0] == $past(tctl_q[3:0]))
      else $error("network 0 bits changed while locked");
   a_tctl_readback: assert property (tctl_wr && !net0_lock && !net1_lock ##1
      rd_req && cmd_addr == ADDR_TERM_CTL |=> rd_valid && rd_data == $past(cmd_wdata, 2))
      else $error("terminal control readback mismatch");
   a_live_waits_done: assert property (!cmd_done |=> $stable(tctl_live_q))
      else $error("switch settings moved before command end");
   a_live_on_done: assert property (cmd_done |=> tctl_live_q == tctl_q)
      else $error("switch settings not applied at command end");
   a_shutdown_forced: assert property (!tctl_live_q[FLD_RUN] |=>
      !term_a_sw[0] && !wiper_sw[0] && wiper_to_b_sw[0])
      else $error("shutdown did not isolate A and tie wiper to B");
   a_zero_tap: assert property (wiper_q[0] == WIPER_ZERO |=> tap_sel[0])
      else $error("zero code did not select terminal B tap");
   a_full_tap: assert property (wiper_q[0] >= FULL |=> tap_sel[TAPS-1])
      else $error("full or reserved code did not select terminal A tap");
   a_tap_onehot: assert property (seen_q |-> $onehot(tap_sel[TAPS-1:0]))
      else $error("tap select not one-hot");
   a_inc_at_full: assert property (cmd_valid && cmd_op == TDC_OP_INC &&
      cmd_addr == ADDR_WIPER0 && wiper_q[0] >= FULL |=> $stable(wiper_q[0]))
      else $error("increment moved wiper at full scale");

   c_shutdown: cover property (tctl_live_q[FLD_RUN] ##1 !tctl_live_q[FLD_RUN]);
   c_locked_write: cover property (tctl_wr && (net0_lock || net1_lock));
   c_reach_full: cover property (cmd_op == TDC_OP_INC && hit_full ##1 wiper_q[0] == FULL);
endmodule : tdc_terminal_ctl

// >>> core/tdc_pkg.sv
// Purpose: Shared constants and types for terminal connect and wiper decode
// Assumes: 9-bit register words, one or two resistor networks
// Notes:   Field positions are offsets inside a 4-bit per-network group
package tdc_pkg;

   typedef logic [8:0] tdc_word_t;

   // Command opcodes handed over by the serial protocol engine
   typedef enum logic [1:0] {
      TDC_OP_WRITE = 2'h0,
      TDC_OP_INC   = 2'h1,
      TDC_OP_DEC   = 2'h2,
      TDC_OP_READ  = 2'h3
   } tdc_op_t;

   // Register addresses
   localparam logic [3:0] ADDR_WIPER0 = 4'h0;
   localparam logic [3:0] ADDR_WIPER1 = 4'h1;
   localparam logic [3:0] ADDR_TERM_CTL = 4'h4;

   // Terminal control layout
   localparam tdc_word_t TERM_CTL_RESET = 9'h1FF;
   localparam int        GC_ACCEPT_POS  = 8;
   localparam int        NET_FIELD_W  = 4;
   localparam int        FLD_RUN      = 3;
   localparam int        FLD_A        = 2;
   localparam int        FLD_W        = 1;
   localparam int        FLD_B        = 0;

   // Wiper scale codes
   localparam tdc_word_t WIPER_ZERO   = 9'h000;
   localparam tdc_word_t WIPER_FULL_7 = 9'h080;
   localparam tdc_word_t WIPER_FULL_8 = 9'h100;
   localparam tdc_word_t WIPER_MID_8  = 9'h080;

   // Full-scale code for a given resolution
   function automatic tdc_word_t tdc_full_scale(input int res_bits);
      return (res_bits == 7) ? WIPER_FULL_7 : WIPER_FULL_8;
   endfunction : tdc_full_scale

endpackage : tdc_pkg

// >>> core/tdc_tap_if.sv
// Purpose: Carries one network's stored settings to its decoder and back
// Assumes: TAPS equals ladder resistors plus one
// Notes:   ctl side drives settings, dec side drives switch enables
interface tdc_tap_if #(
   parameter int TAPS = 257
);
   import tdc_pkg::*;

   tdc_word_t         wiper;
   logic              run;
   logic              con_a;
   logic              con_w;
   logic              con_b;
   logic [TAPS-1:0]   tap_sel;
   logic              sw_a;
   logic              sw_b;
   logic              sw_w;
   logic              sw_wb_short;

   modport ctl (output wiper, run, con_a, con_w, con_b,
                input  tap_sel, sw_a, sw_b, sw_w, sw_wb_short);
   modport dec (input  wiper, run, con_a, con_w, con_b,
                output tap_sel, sw_a, sw_b, sw_w, sw_wb_short);
endinterface : tdc_tap_if

// >>> core/tdc_tap_decode.sv
// Purpose: Turns one network's wiper code and connect bits into switch enables
// Assumes: Wiper code is 9 bits, resolution 7 or 8
// Notes:   All outputs registered, one cycle after the settings change
module tdc_tap_decode
   import tdc_pkg::*;
#(
   parameter int RES_BITS = 8
) (
   input  wire logic  mclk,
   input  wire logic  rstn,
   tdc_tap_if.dec     tap
);
   localparam int        TAPS = (1 << RES_BITS) + 1;
   localparam tdc_word_t FULL = tdc_full_scale(RES_BITS);

   // Codes above full scale still land on the terminal A tap
   wire tdc_word_t       code  = (tap.wiper > FULL) ? FULL : tap.wiper;
   wire [TAPS-1:0]       sel_d = {{(TAPS-1){1'b0}}, 1'b1} << code;

   // Shutdown overrides the stored A and W bits without touching them
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tap.tap_sel     <= '0;
         tap.sw_a        <= 1'b0;
         tap.sw_b        <= 1'b0;
         tap.sw_w        <= 1'b0;
         tap.sw_wb_short <= 1'b0;
      end else begin
         tap.tap_sel     <= sel_d;
         tap.sw_a        <= tap.run & tap.con_a;
         tap.sw_b        <= tap.con_b;
         tap.sw_w        <= tap.run & tap.con_w;
         tap.sw_wb_short <= ~tap.run;
      end
   end
endmodule : tdc_tap_decode

// >>> test/tdc_host_model.sv
// Purpose: Host controller model issuing parsed register commands
// Assumes: Requests launched 1 ns after the rising clock edge
// Notes:   Released address and data lines show inverted data so stale values never pass
module tdc_host_model
   import tdc_pkg::*;
(
   input  wire logic       mclk,
   output logic            cmd_valid,
   output tdc_op_t         cmd_op,
   output logic [3:0]      cmd_addr,
   output tdc_word_t       cmd_wdata,
   output logic            cmd_done,
   input  wire logic [8:0] rd_data,
   input  wire logic       rd_valid
);
   timeunit 1ns;
   timeprecision 1ps;

   // One request held for one whole cycle, answer taken one edge later
   task automatic send(input logic v, input tdc_op_t op, input logic [3:0] a,
                       input tdc_word_t d, input logic done, output logic [9:0] resp);
      @(posedge mclk);
      #1;
      cmd_valid = v;
      cmd_op    = op;
      cmd_addr  = a;
      cmd_wdata = d;
      cmd_done  = done;
      @(posedge mclk);
      #1;
      resp      = {rd_valid, rd_data};
      cmd_valid = 1'b0;
      cmd_done  = 1'b0;
      cmd_addr  = ~a;
      cmd_wdata = ~d;
   endtask : send

   // Idle lines at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd_op    = TDC_OP_READ;
      cmd_addr  = 4'hF;
      cmd_wdata = 9'h1FF;
      cmd_done  = 1'b0;
   end
endmodule : tdc_host_model

// >>> test/terminal_connect_and_wiper_decode_tb.sv
// Purpose: Self-checking bench for terminal control and tap decode
// Assumes: Two networks, 8-bit resolution, wiper reset at mid-scale
// Notes:   Expected values come from bench functions, tables and literals
module terminal_connect_and_wiper_decode_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tdc_pkg::*;
   localparam int TAPS = 257;
   logic mclk, rstn, cmd_valid, cmd_done, net0_lock, net1_lock, rd_valid, gc_en;
   tdc_op_t cmd_op;
   logic [3:0] cmd_addr;
   tdc_word_t cmd_wdata, prev, w;
   logic [8:0] rd_data;
   logic [2*TAPS-1:0] tap_sel;
   logic [1:0] term_a_sw, term_b_sw, wiper_sw, wiper_to_b_sw;
   logic [9:0] resp;
   int bad_count = 0;
   int n_checks = 0;
   tdc_word_t tv[4] = '{9'h0AA, 9'h155, 9'h1FF, 9'h000};
   tdc_word_t wc[8] = '{9'h000, 9'h001, 9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h101, 9'h1FF};
   tdc_word_t st[5] = '{9'h100, 9'h000, 9'h0FF, 9'h001, 9'h101};
   tdc_op_t   so[5] = '{TDC_OP_INC, TDC_OP_DEC, TDC_OP_INC, TDC_OP_DEC, TDC_OP_DEC};
   tdc_word_t se[5] = '{9'h100, 9'h000, 9'h100, 9'h000, 9'h101};

   tdc_terminal_ctl #(.NUM_NETS(2), .RES_BITS(8), .WIPER_RESET(WIPER_MID_8)) u_dut (
      .mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_done(cmd_done),
      .net0_lock(net0_lock), .net1_lock(net1_lock), .rd_data(rd_data),
      .rd_valid(rd_valid), .general_call_accept_enable(gc_en), .tap_sel(tap_sel),
      .term_a_sw(term_a_sw), .term_b_sw(term_b_sw), .wiper_sw(wiper_sw),
      .wiper_to_b_sw(wiper_to_b_sw));

   tdc_host_model u_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_done(cmd_done),
      .rd_data(rd_data), .rd_valid(rd_valid));

   // Clock at 100 MHz
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   // Codes past full scale land on the A end
   function automatic int exp_tap(input tdc_word_t v);
      return (v > WIPER_FULL_8) ? TAPS - 1 : int'(v);
   endfunction : exp_tap

   // Switches {a, b, w, short}; shutdown opens A and wiper, shorts W to B
   function automatic logic [3:0] exp_sw(input logic [3:0] nib);
      return nib[FLD_RUN] ? {nib[FLD_A], nib[FLD_B], nib[FLD_W], 1'b0} : {1'b0, nib[FLD_B], 2'b01};
   endfunction : exp_sw

   task automatic check(input logic [TAPS-1:0] seen, input logic [TAPS-1:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check

   task automatic chk_sw(input int n, input logic [3:0] nib);
      check({term_a_sw[n], term_b_sw[n], wiper_sw[n], wiper_to_b_sw[n]}, exp_sw(nib), "switches");
   endtask : chk_sw

   task automatic wr(input logic [3:0] a, input tdc_word_t d, input logic done);
      u_host.send(1'b1, TDC_OP_WRITE, a, d, done, resp);
   endtask : wr

   task automatic rd(input logic [3:0] a, input tdc_word_t exp, input string what);
      u_host.send(1'b1, TDC_OP_READ, a, 9'h000, 1'b0, resp);
      check(resp, {1'b1, exp}, what);
   endtask : rd

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   // Watchdog far beyond the few hundred cycles the tests need
   initial begin
      #50000;
      bad_count++;
      report_and_stop();
   end

   initial begin
      rstn = 1'b0;
      net0_lock = 1'b0;
      net1_lock = 1'b0;
      void'($urandom(32'hd89c));
      tv[3] = 9'($urandom_range(0, 511));
      repeat (6) @(posedge mclk);
      #1 rstn = 1'b1;
      @(posedge mclk);
      #1;
      check(gc_en, 1'b1, "gc reset");
      chk_sw(0, 4'hF);
      chk_sw(1, 4'hF);
      check(tap_sel[TAPS-1:0], 257'(1) << 128, "reset tap");
      rd(ADDR_TERM_CTL, TERM_CTL_RESET, "control reset");
      $display("test reset done");
      // Host rewrites terminal control after reset
      prev = TERM_CTL_RESET;
      foreach (tv[i]) begin
         wr(ADDR_TERM_CTL, tv[i], 1'b0);
         @(posedge mclk);
         #1;
         chk_sw(0, prev[3:0]);
         u_host.send(1'b0, TDC_OP_WRITE, 4'h0, 9'h000, 1'b1, resp);
         @(posedge mclk);
         #1;
         chk_sw(0, tv[i][3:0]);
         chk_sw(1, tv[i][7:4]);
         check(gc_en, tv[i][GC_ACCEPT_POS], "gc enable");
         rd(ADDR_TERM_CTL, tv[i], "control read");
         prev = tv[i];
      end
      $display("test apply done");
      net1_lock = 1'b1;
      wr(ADDR_TERM_CTL, 9'h000, 1'b1);
      rd(ADDR_TERM_CTL, {1'b0, prev[7:4], 4'h0}, "net1 lock");
      net1_lock = 1'b0;
      net0_lock = 1'b1;
      wr(ADDR_TERM_CTL, 9'h1FF, 1'b1);
      rd(ADDR_TERM_CTL, 9'h1F0, "net0 lock");
      net0_lock = 1'b0;
      rd(4'h7, 9'h000, "unmapped");
      $display("test lock done");
      for (int i = 0; i < 24; i++) begin
         w = (i < 8) ? wc[i] : 9'($urandom_range(0, 511));
         wr(4'(i % 2), w, 1'b0);
         @(posedge mclk);
         #1;
         check(tap_sel[(i%2)*TAPS +: TAPS], 257'(1) << exp_tap(w), "tap");
         rd(4'(i % 2), w, "wiper read");
      end
      $display("test decode done");
      foreach (st[i]) begin
         wr(ADDR_WIPER0, st[i], 1'b0);
         u_host.send(1'b1, so[i], ADDR_WIPER0, 9'h000, 1'b0, resp);
         rd(ADDR_WIPER0, se[i], "step");
      end
      $display("test step done");
      report_and_stop();
   end
endmodule : terminal_connect_and_wiper_decode_tb
